// *** src/gic_bus_watchdog.sv ***
// i2c bus watchdog: detects a free or hung bus and clocks a hung bus clear
// assumes scl and sda arrive already synchronised to sys_clk
`timescale 1ns/10ps
module gic_bus_watchdog #(
	parameter int unsigned SLOW_CYCLES = gic_pkg::WD_SLOW_CYC
) (
	// clock and reset
	input  wire logic sys_clk,
	input  wire logic nrst,
	// synchronised bus levels
	input  wire logic sda_s,
	input  wire logic scl_s,
	// control
	input  wire logic wd_off,
	input  wire logic wd_fast,
	// results
	output logic      bus_free_q,
	output logic      scl_oe_q
);

	gic_pkg::gic_wd_state_t          st_q, st_d;
	logic [gic_pkg::WD_CNT_W-1:0]    cnt_q, cnt_d;
	logic [gic_pkg::WD_CNT_W-1:0]    limit;
	logic [3:0]                      pcnt_q, pcnt_d;
	logic                            free_d, oe_d;
	logic                            sda_p_q, scl_p_q;
	logic                            activity;

	// idle watch, then nine scl pulses when sda is stuck low
	always_comb begin
		st_d     = st_q;
		cnt_d    = cnt_q;
		pcnt_d   = pcnt_q;
		free_d   = bus_free_q;
		activity = (sda_s != sda_p_q) || (scl_s != scl_p_q);
		limit    = wd_fast ? gic_pkg::WD_CNT_W'(gic_pkg::WD_FAST_CYC) : gic_pkg::WD_CNT_W'(SLOW_CYCLES);
		case (st_q)
			gic_pkg::WD_WATCH: begin
				if (wd_off || activity) begin
					cnt_d = '0;
					if (activity)
						free_d = 1'b0;
				end else if (cnt_q >= limit - 1'b1) begin
					cnt_d = '0;
					if (sda_s) begin
						free_d = 1'b1;
					end else begin
						st_d   = gic_pkg::WD_LOW;
						pcnt_d = '0;
					end
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			gic_pkg::WD_LOW: begin
				if (cnt_q == gic_pkg::WD_CNT_W'(gic_pkg::CLR_HALF_CYC - 1)) begin
					cnt_d = '0;
					st_d  = gic_pkg::WD_HIGH;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			gic_pkg::WD_HIGH: begin
				if (cnt_q == gic_pkg::WD_CNT_W'(gic_pkg::CLR_HALF_CYC - 1)) begin
					cnt_d  = '0;
					pcnt_d = pcnt_q + 1'b1;
					st_d   = (pcnt_q == gic_pkg::CLR_PULSES - 1'b1) ? gic_pkg::WD_WATCH : gic_pkg::WD_LOW;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			default: begin
				st_d  = gic_pkg::WD_WATCH;
				cnt_d = '0;
			end
		endcase
		if (wd_off && st_q != gic_pkg::WD_WATCH) begin
			st_d  = gic_pkg::WD_WATCH;
			cnt_d = '0;
		end
		oe_d = (st_d == gic_pkg::WD_LOW);
	end

	// watchdog registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			st_q       <= gic_pkg::WD_WATCH;
			cnt_q      <= '0;
			pcnt_q     <= '0;
			bus_free_q <= 1'b0;
			scl_oe_q   <= 1'b0;
			sda_p_q    <= 1'b1;
			scl_p_q    <= 1'b1;
		end else begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			pcnt_q     <= pcnt_d;
			bus_free_q <= free_d;
			scl_oe_q   <= oe_d;
			sda_p_q    <= sda_s;
			scl_p_q    <= scl_s;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// disabled watchdog never pulls scl
	wd_off_quiet_a: assert property (wd_off |=> !scl_oe_q)
		else $error("watchdog drove scl while disabled");

	// clear sequence ends after exactly nine pulses
	clear_nine_a: assert property (($past(st_q) == gic_pkg::WD_HIGH && st_q == gic_pkg::WD_WATCH && !$past(wd_off))
		|-> $past(pcnt_q) == 4'h8)
		else $error("bus clear ended after wrong pulse count");

	// each low phase lasts at least eight clocks
	clear_low_a: assert property ($rose(scl_oe_q) && !wd_off |-> scl_oe_q [*8])
		else $error("scl clear low phase too short");

	// bus declared free only while sda high
	free_sda_a: assert property ($rose(bus_free_q) |-> $past(sda_s, 1))
		else $error("bus free flagged with sda low");

	// fast expiry pulls a low bus within the short interval
	fast_hang_a: assert property ($rose(scl_oe_q) && $past(wd_fast) && $past(st_q) == gic_pkg::WD_WATCH
		|-> $past(cnt_q) == gic_pkg::WD_CNT_W'(gic_pkg::WD_FAST_CYC - 1))
		else $error("fast watchdog expired at wrong count");

endmodule

// *** src/gic_cfg_regs.sv ***
// pin pair and i2c side configuration registers with the behaviour behind them
// assumes an i2c slave front end on sys_clk delivers register accesses and
// marks those arriving over the control channel; remote pin values share sys_clk
//
// Operation
// - enabled output pin drives local value
// - remote enable drives pin from deserializer
// - sda output delay 350 to 500 ns
// - write lock rejects control channel register writes
// - write lock never blocks remote slave access
// - speed-up bit picks 50 us or 1 s
// - disable bit stops the bus watchdog
// - idle bus with sda high is free
// - stuck sda low gets nine scl pulses
`timescale 1ns/10ps
module gic_cfg_regs #(
	parameter int unsigned WD_SLOW_CYCLES = gic_pkg::WD_SLOW_CYC
) (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	// register access from the i2c slave front end
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	input  wire logic       reg_remote,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata_q,
	output logic            reg_reject_q,
	// remote master pass-through to local slaves
	input  wire logic       fwd_req,
	output logic            fwd_grant_q,
	// general pins
	input  wire logic [1:0] remote_pin_val,
	output logic            second_general_pin_out_q,
	output logic            second_general_pin_oe_q,
	output logic            third_general_pin_out_q,
	output logic            third_general_pin_oe_q,
	// local i2c bus
	input  wire logic       sda_in,
	input  wire logic       scl_in,
	input  wire logic       sda_drive_req,
	output logic            sda_oe_q,
	output logic            scl_oe_q,
	output logic            bus_free_q
);

	// refuse a slow expiry below the fast one or beyond the counter
	if (WD_SLOW_CYCLES < gic_pkg::WD_FAST_CYC || WD_SLOW_CYCLES >= (1 << gic_pkg::WD_CNT_W)) begin : g_slow_range
		$error("WD_SLOW_CYCLES out of range");
	end

	logic [7:0]                      pin_q, pin_d;
	logic [7:0]                      i2c_q, i2c_d;
	logic [7:0]                      rdata_d;
	logic                            reject_d, grant_d, wr_ok;
	logic                            p2_out_d, p2_oe_d, p3_out_d, p3_oe_d;
	logic [gic_pkg::SDA_PIPE_W-1:0]  pipe_q, pipe_d;
	logic                            sda_oe_d;
	logic [1:0]                      sda_code;
	logic                            sda_m_q, sda_s_q, scl_m_q, scl_s_q;

	// register writes, reads, write lock and pin drive
	always_comb begin
		pin_d    = pin_q;
		i2c_d    = i2c_q;
		rdata_d  = reg_rdata_q;
		wr_ok    = reg_wr && !(reg_remote && i2c_q[gic_pkg::LWD_BIT]);
		reject_d = reg_wr && !wr_ok;
		grant_d  = fwd_req;
		if (wr_ok && reg_addr == gic_pkg::ADDR_PIN_CFG)
			pin_d = reg_wdata & gic_pkg::PIN_CFG_MASK;
		if (wr_ok && reg_addr == gic_pkg::ADDR_I2C_CFG)
			i2c_d = reg_wdata & gic_pkg::I2C_CFG_MASK;
		if (reg_rd) begin
			case (reg_addr)
				gic_pkg::ADDR_PIN_CFG: rdata_d = pin_q;
				gic_pkg::ADDR_I2C_CFG: rdata_d = i2c_q;
				default:               rdata_d = gic_pkg::RDATA_NONE;
			endcase
		end
		// second pin has no direction bit and is an output whenever enabled
		p2_oe_d  = pin_q[gic_pkg::P2_EN];
		p2_out_d = pin_q[gic_pkg::P2_REM] ? remote_pin_val[0] : pin_q[gic_pkg::P2_VAL];
		p3_oe_d  = pin_q[gic_pkg::P3_EN] && !pin_q[gic_pkg::P3_DIR];
		p3_out_d = pin_q[gic_pkg::P3_REM] ? remote_pin_val[1] : pin_q[gic_pkg::P3_VAL];
	end

	// register bank and pin outputs
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pin_q                    <= gic_pkg::PIN_CFG_RESET;
			i2c_q                    <= gic_pkg::I2C_CFG_RESET;
			reg_rdata_q              <= gic_pkg::RDATA_NONE;
			reg_reject_q             <= 1'b0;
			fwd_grant_q              <= 1'b0;
			second_general_pin_out_q <= 1'b0;
			second_general_pin_oe_q  <= 1'b0;
			third_general_pin_out_q  <= 1'b0;
			third_general_pin_oe_q   <= 1'b0;
		end else begin
			pin_q                    <= pin_d;
			i2c_q                    <= i2c_d;
			reg_rdata_q              <= rdata_d;
			reg_reject_q             <= reject_d;
			fwd_grant_q              <= grant_d;
			second_general_pin_out_q <= p2_out_d;
			second_general_pin_oe_q  <= p2_oe_d;
			third_general_pin_out_q  <= p3_out_d;
			third_general_pin_oe_q   <= p3_oe_d;
		end
	end

	// sda delay line, tap chosen by the delay code
	always_comb begin
		sda_code = i2c_q[gic_pkg::SDA_DLY_HI:gic_pkg::SDA_DLY_LO];
		pipe_d   = {pipe_q[gic_pkg::SDA_PIPE_W-2:0], sda_drive_req};
		sda_oe_d = pipe_q[gic_pkg::sda_dly_cycles(sda_code) - 2];
	end

	// sda delay registers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pipe_q   <= '0;
			sda_oe_q <= 1'b0;
		end else begin
			pipe_q   <= pipe_d;
			sda_oe_q <= sda_oe_d;
		end
	end

	// two-stage synchronisers for the bus pins
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sda_m_q <= 1'b1;
			sda_s_q <= 1'b1;
			scl_m_q <= 1'b1;
			scl_s_q <= 1'b1;
		end else begin
			sda_m_q <= sda_in;
			sda_s_q <= sda_m_q;
			scl_m_q <= scl_in;
			scl_s_q <= scl_m_q;
		end
	end

	// bus watchdog
	gic_bus_watchdog #(
		.SLOW_CYCLES (WD_SLOW_CYCLES)
	) u_watchdog (
		.sys_clk    (sys_clk),
		.nrst       (nrst),
		.sda_s      (sda_s_q),
		.scl_s      (scl_s_q),
		.wd_off     (i2c_q[gic_pkg::WD_OFF]),
		.wd_fast    (i2c_q[gic_pkg::WD_FAST]),
		.bus_free_q (bus_free_q),
		.scl_oe_q   (scl_oe_q)
	);

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	// locked remote write leaves both registers untouched
	reject_hold_a: assert property (reg_wr && reg_remote && i2c_q[gic_pkg::LWD_BIT]
		|=> reg_reject_q && $stable(pin_q) && $stable(i2c_q))
		else $error("locked remote write changed a register");

	// local write lands regardless of the lock
	local_wr_a: assert property (reg_wr && !reg_remote && reg_addr == gic_pkg::ADDR_PIN_CFG
		|=> pin_q == ($past(reg_wdata) & gic_pkg::PIN_CFG_MASK))
		else $error("local write to pin register lost");

	// pass-through granted one clock after request even when locked
	fwd_pass_a: assert property (fwd_req |=> fwd_grant_q)
		else $error("remote slave access blocked");

	// disabled pin is released two clocks after the write
	pin_tri_a: assert property (reg_wr && !reg_remote && reg_addr == gic_pkg::ADDR_PIN_CFG
		&& !reg_wdata[gic_pkg::P2_EN] |=> ##1 !second_general_pin_oe_q)
		else $error("second pin driven while disabled");

	// enabled output pin follows local or remote source
	pin3_drive_a: assert property ($past(pin_q[4]) && !$past(pin_q[5]) |-> third_general_pin_oe_q &&
		third_general_pin_out_q == ($past(pin_q[6]) ? $past(remote_pin_val[1]) : $past(pin_q[7])))
		else $error("third pin drive wrong");

	// shortest sda delay is seven clocks
	sda_dly_min_a: assert property ($past(i2c_q[4:3]) == 2'b00 |-> sda_oe_q == $past(sda_drive_req, 7))
		else $error("sda delay code 00 wrong");

	// longest sda delay is ten clocks
	sda_dly_max_a: assert property ($past(i2c_q[4:3]) == 2'b11 |-> sda_oe_q == $past(sda_drive_req, 10))
		else $error("sda delay code 11 wrong");

	// reserved bits never read back set
	rsvd_zero_a: assert property (pin_q[1] == 1'b0 && i2c_q[7:5] == 3'h0)
		else $error("reserved bit set");

	// enabled second pin follows local or remote source, from the second edge after reset
	pin2_drive_a: assert property ($past(nrst) && $past(pin_q[gic_pkg::P2_EN])
		|-> second_general_pin_oe_q && second_general_pin_out_q ==
		($past(pin_q[gic_pkg::P2_REM]) ? $past(remote_pin_val[0]) : $past(pin_q[gic_pkg::P2_VAL])))
		else $error("second pin drive wrong");

	// third pin set as input stays released
	pin3_input_a: assert property ($past(pin_q[gic_pkg::P3_DIR]) |-> !third_general_pin_oe_q)
		else $error("third pin driven as input");

	// reject pulses only after a locked remote write
	reject_only_a: assert property (reg_reject_q
		|-> $past(reg_wr && reg_remote && i2c_q[gic_pkg::LWD_BIT]))
		else $error("reject without locked remote write");

	// unlocked remote write to the i2c side register lands
	remote_wr_a: assert property (reg_wr && reg_remote && !i2c_q[gic_pkg::LWD_BIT]
		&& reg_addr == gic_pkg::ADDR_I2C_CFG |=> i2c_q == ($past(reg_wdata) & gic_pkg::I2C_CFG_MASK))
		else $error("unlocked remote write lost");

	// read returns the register held when the strobe was taken
	read_back_a: assert property (reg_rd && reg_addr == gic_pkg::ADDR_I2C_CFG
		|=> reg_rdata_q == $past(i2c_q))
		else $error("register read back wrong");

	// second sda delay code is eight clocks
	sda_dly_one_a: assert property ($past(i2c_q[4:3]) == 2'b01 |-> sda_oe_q == $past(sda_drive_req, 8))
		else $error("sda delay code 01 wrong");

endmodule

// *** src/gic_pkg.sv ***
// package for the pin-pair and i2c-side configuration register block
// assumes a 20 mhz system clock; shared by the register bank and its watchdog
package gic_pkg;

	// clock
	localparam int unsigned CLK_PERIOD_NS = 50;

	// register map and reset values
	localparam logic [7:0] ADDR_PIN_CFG  = 8'h0e;
	localparam logic [7:0] ADDR_I2C_CFG  = 8'h0f;
	localparam logic [7:0] PIN_CFG_RESET = 8'h35;
	localparam logic [7:0] I2C_CFG_RESET = 8'h00;
	localparam logic [7:0] PIN_CFG_MASK  = 8'hfd; // bit 1 reserved
	localparam logic [7:0] I2C_CFG_MASK  = 8'h1f; // bits 7:5 reserved
	localparam logic [7:0] RDATA_NONE    = 8'h00;

	// pin pair field positions
	localparam int unsigned P3_VAL = 7;
	localparam int unsigned P3_REM = 6;
	localparam int unsigned P3_DIR = 5;
	localparam int unsigned P3_EN  = 4;
	localparam int unsigned P2_VAL = 3;
	localparam int unsigned P2_REM = 2;
	localparam int unsigned P2_EN  = 0;

	// i2c side field positions
	localparam int unsigned SDA_DLY_HI = 4;
	localparam int unsigned SDA_DLY_LO = 3;
	localparam int unsigned LWD_BIT    = 2;
	localparam int unsigned WD_FAST    = 1;
	localparam int unsigned WD_OFF     = 0;

	// sda output delay timing, least times round up
	localparam int unsigned SDA_BASE_NS  = 350;
	localparam int unsigned SDA_STEP_NS  = 50;
	localparam int unsigned SDA_BASE_CYC = (SDA_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SDA_STEP_CYC = (SDA_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SDA_PIPE_W   = SDA_BASE_CYC + 3 * SDA_STEP_CYC - 1;

	// watchdog timing, approximate expiries round down
	localparam int unsigned WD_FAST_NS   = 50000;
	localparam int unsigned WD_SLOW_MS   = 1000;
	localparam int unsigned WD_FAST_CYC  = WD_FAST_NS / CLK_PERIOD_NS;
	localparam int unsigned WD_SLOW_CYC  = (WD_SLOW_MS * 1000) / CLK_PERIOD_NS * 1000;
	localparam int unsigned WD_CNT_W     = 25;
	localparam int unsigned CLR_HALF_NS  = 5000;
	localparam int unsigned CLR_HALF_CYC = CLR_HALF_NS / CLK_PERIOD_NS;
	localparam logic [3:0]  CLR_PULSES   = 4'h9;

	// watchdog states
	typedef enum logic [2:0] {
		WD_WATCH = 3'b001,
		WD_LOW   = 3'b010,
		WD_HIGH  = 3'b100
	} gic_wd_state_t;

	// clocks from an sda change request to the pin for a delay code
	function automatic int unsigned sda_dly_cycles(input logic [1:0] code);
		return SDA_BASE_CYC + int'(code) * SDA_STEP_CYC;
	endfunction

endpackage

// *** testbench/gic_bus_partner.sv ***
// local i2c bus model: open-drain sda and scl with pull-ups, plus a slave
// assumes device enables are high while the device pulls a line low
`timescale 1ns/10ps
module gic_bus_partner (
	// device pull-downs
	input  wire logic sda_oe,
	input  wire logic scl_oe,
	// slave that hangs the bus
	input  wire logic hold_sda_low,
	// resolved line levels
	output logic      sda_line,
	output logic      scl_line
);
	// pull-ups win unless some party pulls low
	assign sda_line = !(sda_oe | hold_sda_low);
	assign scl_line = !scl_oe;
endmodule

// *** testbench/gic_cfg_regs_bench.sv ***
// self-checking bench for the configuration register block
// assumes the bus partner model and the design package are compiled first
`timescale 1ns/10ps
module gic_cfg_regs_bench;
	logic sys_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, reg_remote = 0, fwd_req = 0;
	logic sda_drive_req = 0, hold_low = 0, rej, sda_l, scl_l;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata, rdq;
	logic [1:0] remote_pin_val = 2'b00;
	logic reject, grant, out2, oe2, out3, oe3, sda_oe, scl_oe, bus_free;
	int err_total = 0, n_compared = 0, cyc = 0, n, k;
	logic [7:0] pv[5] = '{8'h35, 8'h89, 8'hd4, 8'h08, 8'h9d};
	logic [1:0] rv[5] = '{2'b01, 2'b00, 2'b10, 2'b11, 2'b00};
	logic [3:0] pe[5] = '{4'b1100, 4'b1100, 4'b0011, 4'b0000, 4'b1011};

	// clock and hang guard
	initial forever #25 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			tally_and_finish();
		end
	end

	// short slow count keeps the run brief
	gic_cfg_regs #(.WD_SLOW_CYCLES(2000)) i_gic_cfg_regs (
		.sys_clk(sys_clk), .nrst(nrst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_remote(reg_remote),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(rdq), .reg_reject_q(reject),
		.fwd_req(fwd_req), .fwd_grant_q(grant), .remote_pin_val(remote_pin_val),
		.second_general_pin_out_q(out2), .second_general_pin_oe_q(oe2),
		.third_general_pin_out_q(out3), .third_general_pin_oe_q(oe3),
		.sda_in(sda_l), .scl_in(scl_l), .sda_drive_req(sda_drive_req),
		.sda_oe_q(sda_oe), .scl_oe_q(scl_oe), .bus_free_q(bus_free));
	gic_bus_partner i_gic_bus_partner (
		.sda_oe(sda_oe), .scl_oe(scl_oe), .hold_sda_low(hold_low), .sda_line(sda_l), .scl_line(scl_l));

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_count(input int got, input int exp, input string what);
		n_compared++;
		if (got != exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t %s got %0d exp %0d", $time, what, got, exp);
		end
	endtask

	// one register access; reject seen over the two cycles after it
	task automatic acc(input logic wr, input logic rem, input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_wr = wr;
		reg_rd = !wr;
		reg_remote = rem;
		reg_addr = a;
		reg_wdata = d;
		@(negedge sys_clk);
		reg_wr = 0;
		reg_rd = 0;
		rdata = rdq;
		rej = reject;
		@(negedge sys_clk);
		rej = rej | reject;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		acc(0, 0, a, 8'h00);
		chk_byte(rdata, exp, "read");
	endtask

	// count scl pull-down pulses over a span of cycles
	task automatic cnt_rise(input int span, output int cnt);
		logic prev;
		prev = scl_oe;
		cnt = 0;
		repeat (span) begin
			@(negedge sys_clk);
			if (scl_oe === 1'b1 && prev !== 1'b1) cnt++;
			prev = scl_oe;
		end
	endtask

	initial begin
		repeat (8) @(posedge sys_clk);
		@(negedge sys_clk);
		nrst = 1;
		rd(8'h0e, 8'h35);
		rd(8'h0f, 8'h00);
		rd(8'h20, 8'h00);
		// pin modes from local value, remote value, enable and direction
		for (int i = 0; i < 5; i++) begin
			acc(1, 0, 8'h0e, pv[i]);
			remote_pin_val = rv[i];
			repeat (3) @(negedge sys_clk);
			chk_byte({4'h0, oe2, oe2 & out2, oe3, oe3 & out3}, {4'h0, pe[i]}, "pins");
		end
		// sda delay for every code, watchdog off meanwhile
		for (int c = 0; c < 4; c++) begin
			acc(1, 0, 8'h0f, {3'b000, c[1:0], 3'b001});
			sda_drive_req = 1;
			n = 0;
			while (sda_oe !== 1'b1 && n < 20) begin
				@(negedge sys_clk);
				n++;
			end
			chk_count(n, 7 + c, "sda delay");
			sda_drive_req = 0;
			repeat (12) @(negedge sys_clk);
		end
		// write lock against remote register writes only
		acc(1, 0, 8'h0f, 8'h04);
		acc(1, 1, 8'h0e, 8'h00);
		chk_byte({7'h00, rej}, 8'h01, "lock reject");
		rd(8'h0e, 8'h9d);
		acc(1, 1, 8'h0f, 8'h00);
		chk_byte({7'h00, rej}, 8'h01, "lock reject self");
		rd(8'h0f, 8'h04);
		fwd_req = 1;
		@(negedge sys_clk);
		fwd_req = 0;
		chk_byte({7'h00, grant}, 8'h01, "pass-through");
		@(negedge sys_clk);
		chk_byte({7'h00, grant}, 8'h00, "pass-through drop");
		acc(1, 0, 8'h0f, 8'h02);
		acc(1, 1, 8'h0e, 8'hff);
		chk_byte({7'h00, rej}, 8'h00, "unlocked write");
		rd(8'h0e, 8'hfd);
		acc(1, 0, 8'h0f, 8'hff);
		rd(8'h0f, 8'h1f);
		// fast watchdog: free bus, then hung bus clear
		acc(1, 0, 8'h0f, 8'h02);
		n = 0;
		while (bus_free !== 1'b1 && n < 1100) begin
			@(negedge sys_clk);
			n++;
		end
		chk_byte({7'h00, bus_free}, 8'h01, "free fast");
		hold_low = 1;
		repeat (990) @(negedge sys_clk);
		chk_byte({6'h00, bus_free, scl_oe}, 8'h00, "no early clear");
		cnt_rise(1870, k);
		chk_count(k, 9, "clear pulses");
		// slow watchdog on a released bus
		hold_low = 0;
		acc(1, 0, 8'h0f, 8'h00);
		repeat (1900) @(negedge sys_clk);
		chk_byte({7'h00, bus_free}, 8'h00, "slow not yet");
		repeat (200) @(negedge sys_clk);
		chk_byte({7'h00, bus_free}, 8'h01, "free slow");
		// disabled watchdog never clears a hung bus
		acc(1, 0, 8'h0f, 8'h03);
		hold_low = 1;
		cnt_rise(1300, k);
		chk_count(k, 0, "watchdog off");
		hold_low = 0;
		tally_and_finish();
	end
endmodule
